// *** design/rtc_buf2.sv ***
// Small valid/ready buffer, two entries by default
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
module rtc_buf2 #(
   parameter int W     = 16,
   parameter int DEPTH = `RTC_BUF_DEPTH
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   // Drain side
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wrPtr_reg;
   logic [PW-1:0] rdPtr_reg;
   logic [PW:0]   count_reg;
   logic          push;
   logic          pop;

   assign inReady  = (count_reg != (PW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData  = mem_reg[rdPtr_reg];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Storage; no reset needed, count guards the contents
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
         end
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// *** design/rtc_i2c_dev.sv ***
// Device end: I2C slave giving access to the RTC register space
// What this block does
// [RL1] Slave only, oversampled, standard and fast rates
// [RL2] Answers only address 0x32, bit0 direction
// [RL3] Write: address, pointer byte, then data bytes
// [RL4] Acknowledges the pointer byte always, data bytes only while the write buffer has room
// [RL5] Pointer low nibble increments and wraps alone
// [RL6] Host restarts with new pointer for upper nibble
// [RL7] One second busy timeout re-initialises port
// [RL8] After timeout, reads see released line 0xFF
// [RL9] Host reads via pointer write, repeated START
// [RL10] Sends bytes continuously until host NACKs
// [RL11] Host ACKs wanted bytes, NACKs last, STOPs
// [RL12] Pointer kept between transactions
// [RL13] SDA open-drain low only, SCL input
// [RL14] Timeout counted on 32.768 kHz timebase
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
module rtc_i2c_dev import rtc_pkg::*; #(
   parameter int TB_DIV    = `RTC_TB_DIV,
   parameter int TMO_TICKS = `RTC_TMO_TICKS
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Bus pins
   rtc_i2c_if.dev          bus,
   // Register file read side
   output logic [7:0]      regAddr,
   input  wire logic [7:0] rdData,
   // Register file write stream
   output logic            wrValid,
   input  wire logic       wrReady,
   output logic [7:0]      wrAddr,
   output logic [7:0]      wrData,
   // Status
   output logic            busTimeout
);
   localparam int TBW = $clog2(TB_DIV);
   localparam int TOW = $clog2(TMO_TICKS + 1);

   rtc_dstate_t   state_reg;
   rtc_rxkind_t   kind_reg;
   logic [3:0]    bitCnt_reg;
   logic [7:0]    shift_reg;
   logic [7:0]    tx_reg;
   logic [7:0]    ptr_reg;
   logic          sdaOe_reg;
   logic          hostAck_reg;
   logic          timeout_reg;
   logic [2:0]    sclSync_reg;
   logic [2:0]    sdaSync_reg;
   logic [TBW-1:0] tbCnt_reg;
   logic [TOW-1:0] tmoCnt_reg;
   logic          tmoRun_reg;
   logic          sclRise;
   logic          sclFall;
   logic          startSeen;
   logic          stopSeen;
   logic          tbTick;
   logic          tmoHit;
   logic          quiet;
   logic          byteDone;
   logic          addrHit;
   logic          pushNow;
   logic          bufReady;

   // Low nibble steps and wraps, upper nibble is never carried into
   function automatic logic [7:0] nextPtr(input logic [7:0] p);
      nextPtr = (p & `RTC_PTR_HI_MASK) | ((p + 8'h01) & `RTC_PTR_LO_MASK); // RL5
   endfunction

   ////////////////////
   // Pin sampling

   // Two-stage sync, third stage is the previous value for edge finding;
   // at 4 ns sampling even fast mode gives hundreds of samples per bit
   always_ff @(posedge clk) begin
      if (rst) begin
         sclSync_reg <= 3'h7;
         sdaSync_reg <= 3'h7;
      end else begin
         sclSync_reg <= {sclSync_reg[1:0], bus.scl}; // RL1
         sdaSync_reg <= {sdaSync_reg[1:0], bus.sda};
      end
   end

   // Edges and bus conditions from the synchronised levels
   assign sclRise   = sclSync_reg[1] & ~sclSync_reg[2];
   assign sclFall   = ~sclSync_reg[1] & sclSync_reg[2];
   assign startSeen = sclSync_reg[1] & sclSync_reg[2] & sdaSync_reg[2] & ~sdaSync_reg[1];
   assign stopSeen  = sclSync_reg[1] & sclSync_reg[2] & ~sdaSync_reg[2] & sdaSync_reg[1];

   ////////////////////
   // Bus-busy timeout

   // Internal 32.768 kHz tick derived from the core clock
   assign tbTick = (tbCnt_reg == TBW'(TB_DIV - 1));

   always_ff @(posedge clk) begin
      if (rst || tbTick) begin
         tbCnt_reg <= '0;
      end else begin
         tbCnt_reg <= tbCnt_reg + 1'b1; // RL14
      end
   end

   assign tmoHit = tmoRun_reg & tbTick & (tmoCnt_reg == TOW'(TMO_TICKS - 1)); // RL7

   // Runs from address acceptance, cleared by STOP or by its own expiry
   always_ff @(posedge clk) begin
      if (rst || stopSeen || tmoHit) begin
         tmoRun_reg <= 1'b0; // RL14
         tmoCnt_reg <= '0;
      end else if (addrHit) begin
         tmoRun_reg <= 1'b1; // RL14
         tmoCnt_reg <= '0;
      end else if (tmoRun_reg && tbTick) begin
         tmoCnt_reg <= tmoCnt_reg + 1'b1;
      end
   end

   // One-cycle status pulse on expiry
   always_ff @(posedge clk) begin
      if (rst) begin
         timeout_reg <= 1'b0;
      end else begin
         timeout_reg <= tmoHit;
      end
   end

   ////////////////////
   // Protocol engine

   assign quiet    = ~tmoHit & ~stopSeen & ~startSeen;
   assign byteDone = sclFall & (bitCnt_reg == `RTC_BYTE_DONE);
   assign addrHit  = quiet & (state_reg == DS_RX) & (kind_reg == RK_ADDR) & byteDone &
                     (shift_reg[7:1] == `RTC_SLAVE_ADDR); // RL2
   // A full buffer refuses the byte with NACK, since SCL cannot be stretched
   assign pushNow  = quiet & (state_reg == DS_RX) & (kind_reg == RK_DATA) & byteDone &
                     bufReady; // RL3

   // Bus conditions first, then bit handling on the SCL edges
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg   <= DS_IDLE;
         kind_reg    <= RK_ADDR;
         bitCnt_reg  <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         ptr_reg     <= `RTC_PTR_RESET;
         sdaOe_reg   <= 1'b0; // RL13
         hostAck_reg <= 1'b0;
      end else if (tmoHit || stopSeen) begin
         state_reg <= DS_IDLE; // RL7
         sdaOe_reg <= 1'b0; // RL8
      end else if (startSeen) begin
         state_reg  <= DS_RX;
         kind_reg   <= RK_ADDR;
         bitCnt_reg <= 4'h0;
         sdaOe_reg  <= 1'b0;
      end else begin
         case (state_reg)
            DS_RX: begin
               if (sclRise) begin
                  shift_reg  <= {shift_reg[6:0], sdaSync_reg[1]};
                  bitCnt_reg <= bitCnt_reg + 4'h1;
               end else if (byteDone) begin
                  bitCnt_reg <= 4'h0;
                  state_reg  <= DS_RXACK;
                  case (kind_reg)
                     RK_ADDR: begin
                        sdaOe_reg   <= addrHit;
                        hostAck_reg <= addrHit;
                        if (!addrHit) begin
                           state_reg <= DS_IDLE;
                        end
                     end
                     RK_PTR: begin
                        ptr_reg     <= shift_reg; // RL3
                        sdaOe_reg   <= 1'b1; // RL4
                        hostAck_reg <= 1'b1;
                     end
                     default: begin
                        sdaOe_reg   <= pushNow; // RL4
                        hostAck_reg <= pushNow;
                        if (pushNow) begin
                           ptr_reg <= nextPtr(ptr_reg); // RL5
                        end
                     end
                  endcase
               end
            end
            DS_RXACK: begin
               if (sclFall) begin
                  sdaOe_reg <= 1'b0;
                  if (!hostAck_reg) begin
                     state_reg <= DS_IDLE;
                  end else if (kind_reg == RK_ADDR && shift_reg[0]) begin
                     // Read starts at the kept pointer
                     tx_reg     <= rdData; // RL12
                     sdaOe_reg  <= ~rdData[7]; // RL13
                     bitCnt_reg <= 4'h1;
                     state_reg  <= DS_TX; // RL10
                  end else begin
                     kind_reg  <= (kind_reg == RK_ADDR) ? RK_PTR : RK_DATA; // RL3
                     state_reg <= DS_RX; // RL4
                  end
               end
            end
            DS_TX: begin
               if (sclFall) begin
                  if (bitCnt_reg == `RTC_BYTE_DONE) begin
                     sdaOe_reg <= 1'b0;
                     ptr_reg   <= nextPtr(ptr_reg); // RL5
                     state_reg <= DS_TXACK;
                  end else begin
                     tx_reg     <= {tx_reg[6:0], 1'b0};
                     sdaOe_reg  <= ~tx_reg[6]; // RL13
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end
               end
            end
            DS_TXACK: begin
               if (sclRise) begin
                  hostAck_reg <= ~sdaSync_reg[1];
               end else if (sclFall) begin
                  if (hostAck_reg) begin
                     tx_reg     <= rdData; // RL10
                     sdaOe_reg  <= ~rdData[7];
                     bitCnt_reg <= 4'h1;
                     state_reg  <= DS_TX;
                  end else begin
                     state_reg <= DS_IDLE; // RL10
                  end
               end
            end
            default: begin
               sdaOe_reg <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////
   // Outputs

   // Write stream buffer absorbs short stalls of the register file
   rtc_buf2 #(
      .W     (16),
      .DEPTH (`RTC_BUF_DEPTH)
   ) u_wrBuf (
      .clk      (clk),
      .rst      (rst),
      .inValid  (pushNow),
      .inReady  (bufReady),
      .inData   ({ptr_reg, shift_reg}),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  ({wrAddr, wrData})
   );

   // Drive low only; releasing gives high via the pull-up
   assign bus.sdaDevOut = 1'b0; // RL13
   assign bus.sdaDevOe  = sdaOe_reg;
   assign regAddr       = ptr_reg;
   assign busTimeout    = timeout_reg;
endmodule
`default_nettype wire

// *** design/rtc_i2c_host.sv ***
// Host end: byte-level I2C master for the RTC register port
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
module rtc_i2c_host import rtc_pkg::*; #(
   parameter int QUARTER = `RTC_FAST_QTR
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Bus pins
   rtc_i2c_if.host         bus,
   // Command port
   input  wire logic       cmdValid,
   output logic            cmdReady,
   input  wire rtc_hop_t   cmdOp,
   input  wire logic [7:0] cmdData,
   input  wire logic       cmdAck,
   // Response stream
   output logic            rspValid,
   input  wire logic       rspReady,
   output logic [7:0]      rspData,
   output logic            rspAck
);
   localparam int QW = (QUARTER > 1) ? $clog2(QUARTER) : 1;

   rtc_hstate_t state_reg;
   logic [1:0]  phase_reg;
   logic [3:0]  bitIdx_reg;
   logic [8:0]  txBits_reg;
   logic [8:0]  rxBits_reg;
   logic        sclHigh_reg;
   logic        sdaHigh_reg;
   logic [1:0]  sdaSync_reg;
   logic [QW-1:0] qCnt_reg;
   logic        qTick;
   logic        bufReady;
   logic        rspPush;

   ////////////////////
   // Timing

   // Data line comes back from the far end, so it is synchronised
   always_ff @(posedge clk) begin
      if (rst) begin
         sdaSync_reg <= 2'h3;
      end else begin
         sdaSync_reg <= {sdaSync_reg[0], bus.sda};
      end
   end

   // Quarter-bit divider, held at zero while idle
   assign qTick = (qCnt_reg == QW'(QUARTER - 1));

   always_ff @(posedge clk) begin
      if (rst || state_reg == HS_IDLE || qTick) begin
         qCnt_reg <= '0;
      end else begin
         qCnt_reg <= qCnt_reg + 1'b1;
      end
   end

   ////////////////////
   // Sequencer

   // Commands wait for room in the response buffer so no answer is lost
   assign cmdReady = (state_reg == HS_IDLE) & bufReady;
   assign rspPush  = (state_reg == HS_BIT) & qTick & (phase_reg == 2'h3) &
                     (bitIdx_reg == `RTC_BYTE_DONE);

   // Each bit is four quarters: set data, raise clock, sample, drop clock
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg   <= HS_IDLE;
         phase_reg   <= 2'h0;
         bitIdx_reg  <= 4'h0;
         txBits_reg  <= 9'h1ff;
         rxBits_reg  <= 9'h000;
         sclHigh_reg <= 1'b1;
         sdaHigh_reg <= 1'b1;
      end else if (state_reg == HS_IDLE) begin
         if (cmdValid && cmdReady) begin
            phase_reg  <= 2'h0;
            bitIdx_reg <= 4'h0;
            case (cmdOp)
               HOP_START: state_reg <= HS_START; // RL6
               HOP_STOP:  state_reg <= HS_STOP; // RL11
               HOP_WRITE: begin
                  state_reg  <= HS_BIT; // RL3
                  txBits_reg <= {cmdData, 1'b1};
               end
               default: begin
                  state_reg  <= HS_BIT;
                  txBits_reg <= {`RTC_IDLE_BYTE, ~cmdAck}; // RL11
               end
            endcase
         end
      end else if (qTick) begin
         phase_reg <= phase_reg + 2'h1;
         case (state_reg)
            HS_START: begin
               // Also serves as repeated START from a low clock
               case (phase_reg)
                  2'h0: sdaHigh_reg <= 1'b1;
                  2'h1: sclHigh_reg <= 1'b1;
                  2'h2: sdaHigh_reg <= 1'b0; // RL9
                  default: begin
                     sclHigh_reg <= 1'b0;
                     state_reg   <= HS_IDLE;
                  end
               endcase
            end
            HS_STOP: begin
               case (phase_reg)
                  2'h0: sdaHigh_reg <= 1'b0;
                  2'h1: sclHigh_reg <= 1'b1;
                  2'h2: sdaHigh_reg <= 1'b1; // RL11
                  default: state_reg <= HS_IDLE;
               endcase
            end
            default: begin
               case (phase_reg)
                  2'h0: sdaHigh_reg <= txBits_reg[8];
                  2'h1: sclHigh_reg <= 1'b1;
                  2'h2: rxBits_reg <= {rxBits_reg[7:0], sdaSync_reg[1]};
                  default: begin
                     sclHigh_reg <= 1'b0;
                     txBits_reg  <= {txBits_reg[7:0], 1'b1};
                     bitIdx_reg  <= bitIdx_reg + 4'h1;
                     if (bitIdx_reg == `RTC_BYTE_DONE) begin
                        state_reg <= HS_IDLE;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   ////////////////////
   // Outputs

   rtc_buf2 #(
      .W     (9),
      .DEPTH (`RTC_BUF_DEPTH)
   ) u_rspBuf (
      .clk      (clk),
      .rst      (rst),
      .inValid  (rspPush),
      .inReady  (bufReady),
      .inData   ({rxBits_reg[8:1], ~rxBits_reg[0]}),
      .outValid (rspValid),
      .outReady (rspReady),
      .outData  ({rspData, rspAck})
   );

   // Both lines open-drain; the clock is never stretched by the far end
   assign bus.sclHostOut = 1'b0;
   assign bus.sclHostOe  = ~sclHigh_reg;
   assign bus.sdaHostOut = 1'b0;
   assign bus.sdaHostOe  = ~sdaHigh_reg;
endmodule
`default_nettype wire

// *** design/rtc_i2c_if.sv ***
// Two-wire bus joining host and device ends, with pull-up resolution
`timescale 1ns/1ns
`default_nettype none
interface rtc_i2c_if;
   logic sclHostOut;
   logic sclHostOe;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;

   // Open-drain wires: any enabled driver wins, else the pull-up
   assign scl = sclHostOe ? sclHostOut : 1'b1;
   assign sda = (sdaHostOe ? sdaHostOut : 1'b1) & (sdaDevOe ? sdaDevOut : 1'b1);

   modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
   modport host (input scl, input sda, output sclHostOut, output sclHostOe,
                 output sdaHostOut, output sdaHostOe);
endinterface
`default_nettype wire

// *** design/rtc_params.svh ***
// Constants for the RTC I2C register port
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Bus address and pointer layout
`define RTC_SLAVE_ADDR  7'h32
`define RTC_PTR_LO_MASK 8'h0f
`define RTC_PTR_HI_MASK 8'hf0
`define RTC_PTR_RESET   8'h00
`define RTC_IDLE_BYTE   8'hff

// Clock rates in Hz
`define RTC_CLK_HZ      250000000
`define RTC_TB_HZ       32768
`define RTC_STD_BPS     100000
`define RTC_FAST_BPS    400000

// Bus-busy timeout in seconds
`define RTC_TMO_S       1

// Derived counts
`define RTC_TB_DIV      (`RTC_CLK_HZ / `RTC_TB_HZ)
`define RTC_TMO_TICKS   (`RTC_TB_HZ * `RTC_TMO_S)
`define RTC_FAST_QTR    ((`RTC_CLK_HZ + 4 * `RTC_FAST_BPS - 1) / (4 * `RTC_FAST_BPS))
`define RTC_STD_QTR     ((`RTC_CLK_HZ + 4 * `RTC_STD_BPS - 1) / (4 * `RTC_STD_BPS))

// Bit count and buffer depth
`define RTC_BYTE_DONE   4'h8
`define RTC_BUF_DEPTH   2

`endif

// *** design/rtc_pkg.sv ***
// Types shared by both ends of the RTC I2C register port
package rtc_pkg;

   // Device end states
   typedef enum logic [2:0] {
      DS_IDLE  = 3'h0,
      DS_RX    = 3'h1,
      DS_RXACK = 3'h2,
      DS_TX    = 3'h3,
      DS_TXACK = 3'h4
   } rtc_dstate_t;

   // What the byte being received means
   typedef enum logic [1:0] {
      RK_ADDR = 2'h0,
      RK_PTR  = 2'h1,
      RK_DATA = 2'h2
   } rtc_rxkind_t;

   // Host end states
   typedef enum logic [1:0] {
      HS_IDLE  = 2'h0,
      HS_START = 2'h1,
      HS_STOP  = 2'h2,
      HS_BIT   = 2'h3
   } rtc_hstate_t;

   // Host commands
   typedef enum logic [1:0] {
      HOP_START = 2'h0,
      HOP_STOP  = 2'h1,
      HOP_WRITE = 2'h2,
      HOP_READ  = 2'h3
   } rtc_hop_t;

endpackage

// *** tb/rtc_i2c_props.sv ***
// Wire-level assertions for the RTC I2C register port
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
module rtc_i2c_props #(
   parameter int TB_DIV    = 4,
   parameter int TMO_TICKS = 20,
   parameter int QUARTER   = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wires and device enable
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaDevOut,
   input wire logic sdaDevOe
);
   // Margin covers the address byte that restarts the device timer
   localparam int LIMIT = TB_DIV * TMO_TICKS + 40 * QUARTER + 16;
   logic       sclPrev_reg;
   logic       sdaPrev_reg;
   logic [7:0] shift_reg;
   logic [3:0] bitCnt_reg;
   logic [1:0] byteIdx_reg;
   logic       match_reg;
   logic       rdDir_reg;
   int         busyCnt_reg;
   logic       sclRise;
   logic       startSeen;
   logic       ackSlot;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////
   // Edge and condition decode
   assign sclRise   = scl && !sclPrev_reg;
   assign startSeen = scl && sclPrev_reg && sdaPrev_reg && !sda;
   assign ackSlot   = sclRise && bitCnt_reg == 4'h8;
   // Previous levels, idle high so reset shows no edge
   always_ff @(posedge clk) begin
      sclPrev_reg <= rst | scl;
      sdaPrev_reg <= rst | sda;
   end
   // Bit and byte position since the last START
   always_ff @(posedge clk) begin
      if (rst || startSeen) begin
         bitCnt_reg  <= 4'h0;
         byteIdx_reg <= 2'h0;
      end else if (sclRise) begin
         if (!ackSlot) shift_reg <= {shift_reg[6:0], sda};
         bitCnt_reg <= ackSlot ? 4'h0 : bitCnt_reg + 4'h1;
         if (ackSlot && byteIdx_reg != 2'h3) byteIdx_reg <= byteIdx_reg + 2'h1;
      end
   end
   // Address match and direction of the current transfer
   always_ff @(posedge clk) begin
      if (rst || startSeen) begin
         match_reg <= 1'b0;
         rdDir_reg <= 1'b0;
      end else if (ackSlot && byteIdx_reg == 2'h0) begin
         match_reg <= shift_reg[7:1] == `RTC_SLAVE_ADDR;
         rdDir_reg <= shift_reg[0];
      end
   end
   // Cycles since the last START, saturating
   always_ff @(posedge clk) begin
      if (rst || startSeen) busyCnt_reg <= 0;
      else if (busyCnt_reg < LIMIT + 4) busyCnt_reg <= busyCnt_reg + 1;
   end
   ////////////////////
   a_dev_low_only: assert property (sdaDevOe |-> !sdaDevOut)
      else $error("device drove SDA high");
   a_reset_release: assert property ($fell(rst) |-> !sdaDevOe)
      else $error("device drives SDA out of reset");
   a_drive_scl_low: assert property ($rose(sdaDevOe) |-> !scl)
      else $error("device pulled SDA while SCL high");
   a_high_stable: assert property (sclRise |-> ($stable(sdaDevOe)) [*8])
      else $error("device SDA changed while SCL high");
   a_addr_ack: assert property (ackSlot && byteIdx_reg == 2'h0
      |-> sdaDevOe == (shift_reg[7:1] == `RTC_SLAVE_ADDR))
      else $error("address acknowledge wrong");
   a_ptr_ack: assert property (ackSlot && byteIdx_reg == 2'h1 && match_reg && !rdDir_reg
      |-> sdaDevOe)
      else $error("pointer byte not acknowledged");
   a_read_release: assert property (ackSlot && byteIdx_reg != 2'h0 && match_reg && rdDir_reg
      |-> !sdaDevOe)
      else $error("device held SDA in host ack slot");
   a_timeout_release: assert property (busyCnt_reg > LIMIT |-> !sdaDevOe)
      else $error("device still drives after bus timeout");
   // Main scenarios reached
   c_addr_ack: cover property (ackSlot && byteIdx_reg == 2'h0 && sdaDevOe);
   c_addr_nack: cover property (ackSlot && byteIdx_reg == 2'h0 && !sdaDevOe);
   c_timeout: cover property (busyCnt_reg > LIMIT);
endmodule
`default_nettype wire

// *** tb/test_rtc_i2c_slave_register_port.sv ***
// Self-checking bench joining host and device ends of the RTC I2C port
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module test_rtc_i2c_slave_register_port import rtc_pkg::*; ();
   // Shortened timebase so the busy timeout fits the run
   localparam int TB_DIV = 4, TMO_TICKS = 5000, QUARTER = 20;
   logic       clk, rst, cmdValid, cmdReady, cmdAck, rspValid, rspReady, rspAck;
   logic       wrValid, wrReady, busTimeout, ra;
   rtc_hop_t   cmdOp;
   logic [7:0] cmdData, rspData, regAddr, rdData, wrAddr, wrData, rd;
   logic [7:0] mem [256];
   logic [15:0] wrLog [$];
   int         num_errors = 0, n_compared = 0, toCount = 0;
   ////////////////////
   rtc_i2c_if rtc_i2c_if_inst ();
   rtc_i2c_dev #(.TB_DIV(TB_DIV), .TMO_TICKS(TMO_TICKS)) rtc_i2c_dev_inst (.clk(clk),
      .rst(rst), .bus(rtc_i2c_if_inst.dev), .regAddr(regAddr), .rdData(rdData),
      .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData),
      .busTimeout(busTimeout));
   rtc_i2c_host #(.QUARTER(QUARTER)) rtc_i2c_host_inst (.clk(clk), .rst(rst),
      .bus(rtc_i2c_if_inst.host), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdData(cmdData), .cmdAck(cmdAck), .rspValid(rspValid), .rspReady(rspReady),
      .rspData(rspData), .rspAck(rspAck));
   rtc_i2c_props #(.TB_DIV(TB_DIV), .TMO_TICKS(TMO_TICKS), .QUARTER(QUARTER))
      rtc_i2c_props_inst (.clk(clk), .rst(rst), .scl(rtc_i2c_if_inst.scl),
      .sda(rtc_i2c_if_inst.sda), .sdaDevOut(rtc_i2c_if_inst.sdaDevOut),
      .sdaDevOe(rtc_i2c_if_inst.sdaDevOe));
   // Register file stand-in, read combinationally at the pointer
   assign rdData = mem[regAddr];
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Accept write stream entries and count timeout pulses
   always @(posedge clk) begin
      if (wrValid === 1'b1 && wrReady === 1'b1) begin
         mem[wrAddr] <= wrData;
         wrLog.push_back({wrAddr, wrData});
      end
      if (busTimeout === 1'b1) toCount++;
   end
   ////////////////////
   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang();
      num_errors++;
      $display("Error at %0t ns: wait ran out", $time);
      report_and_stop();
   endtask
   // One host command; byte commands return data and ack in rd and ra
   task automatic cmd(input rtc_hop_t op, input logic [7:0] d = 8'h00, input logic a = 1'b0);
      int i;
      cmdOp <= op;
      cmdData <= d;
      cmdAck <= a;
      cmdValid <= 1'b1;
      i = 0;
      do begin @(posedge clk); i++; end while (cmdReady !== 1'b1 && i < 2000);
      cmdValid <= 1'b0;
      if (op == HOP_WRITE || op == HOP_READ) begin
         i = 0;
         do begin @(posedge clk); i++; end while (rspValid !== 1'b1 && i < 2000);
         rd = rspData;
         ra = rspAck;
         rspReady <= 1'b1;
         @(posedge clk);
         rspReady <= 1'b0;
      end else begin
         @(posedge clk);
      end
      if (i >= 2000) hang();
   endtask
   task automatic open_wr(input logic [7:0] p);
      cmd(HOP_START);
      cmd(HOP_WRITE, 8'h64);
      `CHK(ra, 1'b1)
      cmd(HOP_WRITE, p);
      `CHK(ra, 1'b1)
   endtask
   ////////////////////
   task automatic t_write_burst();
      wrLog.delete();
      open_wr(8'h1e);
      for (int k = 0; k < 3; k++) begin
         cmd(HOP_WRITE, 8'ha0 + 8'(k));
         `CHK(ra, 1'b1)
      end
      cmd(HOP_STOP);
      `CHK(wrLog[0], 16'h1ea0)
      `CHK(wrLog[1], 16'h1fa1)
      `CHK(wrLog[2], 16'h10a2)
      $display("t_write_burst done");
   endtask
   task automatic t_read_wrap();
      open_wr(8'h2e);
      cmd(HOP_START);
      cmd(HOP_WRITE, 8'h65);
      `CHK(ra, 1'b1)
      for (int k = 0; k < 3; k++) begin
         cmd(HOP_READ, 8'h00, k < 2);
         `CHK(rd, (8'h20 | ((8'h0e + 8'(k)) & 8'h0f)) ^ 8'h5a)
      end
      cmd(HOP_STOP);
      $display("t_read_wrap done");
   endtask
   task automatic t_read_kept();
      cmd(HOP_START);
      cmd(HOP_WRITE, 8'h65);
      cmd(HOP_READ);
      `CHK(rd, 8'h21 ^ 8'h5a)
      cmd(HOP_STOP);
      $display("t_read_kept done");
   endtask
   task automatic t_wrong_addr();
      wrLog.delete();
      cmd(HOP_START);
      cmd(HOP_WRITE, 8'h66);
      `CHK(ra, 1'b0)
      cmd(HOP_WRITE);
      `CHK(ra, 1'b0)
      cmd(HOP_STOP);
      `CHK(wrLog.size(), 0)
      $display("t_wrong_addr done");
   endtask
   task automatic t_buffer_full();
      int i;
      wrLog.delete();
      wrReady <= 1'b0;
      open_wr(8'h40);
      for (int k = 1; k < 4; k++) begin
         cmd(HOP_WRITE, 8'(k) * 8'h11);
         `CHK(ra, k < 3)
      end
      cmd(HOP_STOP);
      `CHK(wrLog.size(), 0)
      wrReady <= 1'b1;
      i = 0;
      do begin @(posedge clk); i++; end while (wrLog.size() < 2 && i < 20);
      `CHK(wrLog[0], 16'h4011)
      `CHK(wrLog[1], 16'h4122)
      $display("t_buffer_full done");
   endtask
   task automatic t_timeout();
      int i;
      cmd(HOP_START);
      cmd(HOP_WRITE, 8'h65);
      cmd(HOP_READ, 8'h00, 1'b1);
      `CHK(rd, 8'h42 ^ 8'h5a)
      i = 0;
      do begin @(posedge clk); i++; end while (toCount == 0 && i < 25000);
      `CHK(toCount, 1)
      `CHK(rtc_i2c_if_inst.sdaDevOe, 1'b0)
      cmd(HOP_READ);
      `CHK(rd, `RTC_IDLE_BYTE)
      cmd(HOP_STOP);
      open_wr(8'h50);
      cmd(HOP_STOP);
      $display("t_timeout done");
   endtask
   ////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      cmdValid = 1'b0;
      cmdOp = HOP_START;
      cmdData = 8'h00;
      cmdAck = 1'b0;
      rspReady = 1'b0;
      wrReady = 1'b1;
      for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'h5a;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_write_burst();
      t_read_wrap();
      t_read_kept();
      t_wrong_addr();
      t_buffer_full();
      t_timeout();
      report_and_stop();
   end
endmodule
`default_nettype wire
